// ### core/quad_load_pkg.sv
// Shared constants for the quad converter serial load control.
package quad_load_pkg;
  // Serial word layout: address first, two spare bits, code MSB first.
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int ADDR_BITS = 2;
  localparam int NUM_CHANNELS = 4;
  localparam int ADDR_POS = 14;
  localparam int SPARE_POS = 12;
  localparam int CODE_POS = 0;
  // Codes forced while the device reset pin is low.
  localparam logic [11:0] ZERO_SCALE_CODE = 12'h000;
  localparam logic [11:0] MID_SCALE_CODE = 12'h800;
  // Values after the system reset.
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [5:0] PINS_RESET = 6'h3f;
  // Bit buffer between the link sampler and the shift register.
  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 8;
  // Positions of the sampled pins inside the synchroniser vector.
  localparam int PIN_DATA = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_RESET = 4;
  localparam int PIN_SEL = 5;
endpackage

// ### core/bit_stream_if.sv
// Valid/ready carrier between the link sampler, the buffer and the loader.
`timescale 1ns/1ns
`default_nettype none
interface bit_stream_if #(parameter int WIDTH = 1);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### core/bit_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  bit_stream_if.sink fill,
  bit_stream_if.source drain
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0] count_reg, count_next;
  logic push, pop;

  // Full and empty come straight from the occupancy count.
  assign fill.ready = (count_reg != (PW+1)'(DEPTH));
  assign drain.valid = (count_reg != '0);
  assign drain.data = mem_reg[rd_reg];
  assign push = fill.valid & fill.ready;
  assign pop = drain.valid & drain.ready;

  // Pointer and storage update; pointers wrap at the depth.
  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_reg] = fill.data;
      wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      count_reg <= count_next;
    end
    mem_reg <= mem_next;
  end
endmodule
`default_nettype wire

// ### core/quad_load_control.sv
// Serial load control for a quad 12-bit converter with four code registers.
// Summary of operation
// R1: Load strobe low makes the addressed channel follow the shift register.
// R2: Load strobe high keeps every channel register latched and unchanged.
// R3: Reset pin low forces every channel register to 000 or 800 hex.
// R4: Reset select low picks 000 hex, high picks 800 hex.
// R5: Reset acts on all channels at once, needing no serial edge or strobe.
// R6: One transfer is a 16-bit word carrying a 12-bit code for one channel.
// R7: Two address bits pick exactly one of four channel registers.
// R8: The two spare bits between address and code are ignored.
// R9: Each of the four channels keeps its own output register.
// R10: Address first, two spare bits, then code MSB first; 00..11 select A..D.
// R11: Shifting happens on each rising edge of chip select ORed with clock; edges beyond eight queued while the reset pin is low are lost.
// R12: After reset release latched registers keep the reset code until loaded.
// R13: Each channel code is shown continuously as unsigned straight binary.
`timescale 1ns/1ns
`default_nettype none
module quad_load_control
  import quad_load_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic serial_data_in,
  input wire logic serial_clk_in,
  input wire logic chip_select_n_in,
  input wire logic channel_load_strobe_n_in,
  input wire logic device_reset_n_in,
  input wire logic reset_code_select_in,
  output logic bit_buffer_ready_out,
  output logic [CODE_BITS-1:0] channel_a_code_out,
  output logic [CODE_BITS-1:0] channel_b_code_out,
  output logic [CODE_BITS-1:0] channel_c_code_out,
  output logic [CODE_BITS-1:0] channel_d_code_out
);
  logic [5:0] pins_s1_reg, pins_s2_reg;
  logic shift_clk_prev_reg, shift_clk_prev_next;
  logic [WORD_BITS-1:0] shift_reg, shift_next;
  logic [CODE_BITS-1:0] chan_reg [NUM_CHANNELS];
  logic [CODE_BITS-1:0] chan_next [NUM_CHANNELS];
  logic shift_clk, shift_edge, load_n, reset_n, reset_code_sel;
  logic [CODE_BITS-1:0] reset_code, shift_code;
  logic [ADDR_BITS-1:0] shift_addr;

  bit_stream_if #(.WIDTH(FIFO_WIDTH)) push_bus ();
  bit_stream_if #(.WIDTH(FIFO_WIDTH)) pop_bus ();

  // Every pin crosses two flops; only the second stage feeds logic.
  // The pins share one sampling edge, so data and its clock edge stay
  // aligned; the cost is two cycles of latency on every pin.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pins_s1_reg <= PINS_RESET;
      pins_s2_reg <= PINS_RESET;
    end else begin
      pins_s1_reg <= {reset_code_select_in, device_reset_n_in,
                      channel_load_strobe_n_in, chip_select_n_in,
                      serial_clk_in, serial_data_in};
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // The OR of select and clock is the shift clock, so either can shift.
  // The edge detector starts high after reset, matching the idle level of
  // the OR, so no false edge follows the system reset.
  assign shift_clk = pins_s2_reg[PIN_CS] | pins_s2_reg[PIN_SCLK]; // R11
  assign shift_edge = shift_clk & ~shift_clk_prev_reg; // R11
  assign shift_clk_prev_next = shift_clk;
  assign load_n = pins_s2_reg[PIN_LOAD];
  assign reset_n = pins_s2_reg[PIN_RESET];
  assign reset_code_sel = pins_s2_reg[PIN_SEL];
  assign reset_code = reset_code_sel ? MID_SCALE_CODE
                                     : ZERO_SCALE_CODE; // R4

  // Each sampled edge pushes its data bit; the link cannot be paused, so
  // a full buffer shows on the ready port and the bit is lost.
  assign push_bus.valid = shift_edge;
  assign push_bus.data = pins_s2_reg[PIN_DATA];
  assign bit_buffer_ready_out = push_bus.ready;

  // Draining stalls while the reset pin is low; queued bits wait and
  // enter the shift register after release, so the shift register keeps
  // its contents through reset.
  assign pop_bus.ready = reset_n;

  bit_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_bits (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .fill(push_bus),
    .drain(pop_bus)
  );

  // Bits enter at the bottom, so after 16 shifts the first bit sits on top.
  always_comb begin
    shift_next = shift_reg;
    if (pop_bus.valid && pop_bus.ready) begin
      shift_next = {shift_reg[WORD_BITS-2:0], pop_bus.data}; // R6 R10
    end
  end

  // Spare bits at SPARE_POS are never decoded.
  assign shift_addr = shift_reg[ADDR_POS +: ADDR_BITS]; // R7 R10
  assign shift_code = shift_reg[CODE_POS +: CODE_BITS]; // R8 R10

  // One register per channel. Reset beats load; with the strobe low the
  // addressed one follows the shift register, else all hold.
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    assign chan_next[ch] =
      !reset_n ? reset_code : // R3 R5
      (!load_n && shift_addr == ADDR_BITS'(ch)) ? shift_code : // R1 R7
      chan_reg[ch]; // R2 R9 R12
  end

  // Registers only. A system reset clears the codes to zero scale; the
  // device reset pin, not this one, picks the mid-scale code.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      shift_clk_prev_reg <= 1'b1;
      shift_reg <= SHIFT_RESET;
      chan_reg <= '{default: ZERO_SCALE_CODE};
    end else begin
      shift_clk_prev_reg <= shift_clk_prev_next;
      shift_reg <= shift_next;
      chan_reg <= chan_next;
    end
  end

  // Codes leave straight from the channel flops as unsigned binary, so the
  // conversion stage never sees a half-updated word.
  assign channel_a_code_out = chan_reg[0]; // R13
  assign channel_b_code_out = chan_reg[1];
  assign channel_c_code_out = chan_reg[2];
  assign channel_d_code_out = chan_reg[3];

  // Checks run on the system clock and rest while the system reset is up;
  // they work on the synchronised pins, so they see what the logic sees.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  // Reset pin behaviour.
  a_reset_zero_code: assert property ( // R3
    !reset_n && !reset_code_sel |=> chan_reg[0] == 12'h000 &&
      chan_reg[1] == 12'h000 && chan_reg[2] == 12'h000 &&
      chan_reg[3] == 12'h000)
    else $error("zero-scale reset not applied");

  a_reset_mid_code: assert property ( // R4
    !reset_n && reset_code_sel |=> chan_reg[0] == 12'h800 &&
      chan_reg[1] == 12'h800 && chan_reg[2] == 12'h800 &&
      chan_reg[3] == 12'h800)
    else $error("mid-scale reset not applied");

  a_reset_no_edge: assert property ( // R5
    $fell(reset_n) && !shift_edge |=> chan_reg[1] == $past(reset_code))
    else $error("reset waited for a serial edge");

  a_reset_beats_load: assert property ( // R3
    !reset_n && !load_n |=> chan_reg[0] == $past(reset_code) &&
      chan_reg[2] == $past(reset_code))
    else $error("load strobe overrode the reset pin");

  a_keep_reset_code: assert property ( // R12
    $rose(reset_n) && load_n |=> chan_reg[1] == $past(reset_code, 2) &&
      chan_reg[2] == $past(reset_code, 2))
    else $error("reset code lost at release");

  // Load strobe and address decoding.
  a_latched_hold: assert property ( // R2
    load_n && reset_n |=> $stable(chan_reg[2]) && $stable(chan_reg[0]))
    else $error("latched channel changed");

  a_latched_others: assert property ( // R2
    load_n && reset_n |=> $stable(chan_reg[1]) && $stable(chan_reg[3]))
    else $error("latched channel changed");

  a_transparent_follow: assert property ( // R1
    !load_n && reset_n && shift_addr == 2'b01 |=>
      chan_reg[1] == $past(shift_code))
    else $error("addressed channel not transparent");

  a_only_addressed: assert property ( // R7
    !load_n && reset_n && shift_addr == 2'b11 |=>
      $stable(chan_reg[0]) && $stable(chan_reg[1]))
    else $error("unaddressed channel changed");

  a_select_chan_a: assert property ( // R10
    !load_n && reset_n && shift_addr == 2'b00 |=>
      chan_reg[0] == $past(shift_code) && $stable(chan_reg[3]))
    else $error("address zero did not select channel A");

  a_select_chan_c: assert property ( // R10
    !load_n && reset_n && shift_addr == 2'b10 |=>
      chan_reg[2] == $past(shift_code) && $stable(chan_reg[1]))
    else $error("address two did not select channel C");

  a_select_chan_d: assert property ( // R7
    !load_n && reset_n && shift_addr == 2'b11 |=>
      chan_reg[3] == $past(shift_code) && $stable(chan_reg[2]))
    else $error("address three did not select channel D");

  a_spare_unused: assert property ( // R8
    !load_n && reset_n && shift_addr == 2'b10 |=>
      chan_reg[2] == $past(shift_reg[11:0]))
    else $error("spare bits reached a channel code");

  // Serial path into the shift register.
  a_edge_pushes: assert property ( // R11
    $rose(shift_clk) |-> push_bus.valid && push_bus.data ==
      pins_s2_reg[PIN_DATA])
    else $error("shift edge not captured");

  a_edge_queued: assert property ( // R11
    shift_edge && push_bus.ready && !(pop_bus.valid && pop_bus.ready) |=>
      u_bits.count_reg == $past(u_bits.count_reg) + 4'h1)
    else $error("serial edge not queued");

  a_shift_advance: assert property ( // R6
    pop_bus.valid && reset_n |=> shift_reg ==
      {$past(shift_reg[14:0]), $past(pop_bus.data)})
    else $error("shift register did not advance");

  a_shift_hold: assert property ( // R12
    !reset_n |=> $stable(shift_reg))
    else $error("shift register moved during reset");
endmodule
`default_nettype wire

// ### bench/host_model.sv
// Host model driving the serial load and control pins of the block.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk_sys_in,
  output logic serial_data_out,
  output logic serial_clk_out,
  output logic chip_select_n_out,
  output logic channel_load_strobe_n_out,
  output logic device_reset_n_out,
  output logic reset_code_select_out
);
  // Idle pins: link clock stands high between frames, nothing selected.
  initial begin
    serial_data_out = 1'b0;
    serial_clk_out = 1'b1;
    chip_select_n_out = 1'b1;
    channel_load_strobe_n_out = 1'b1;
    device_reset_n_out = 1'b1;
    reset_code_select_out = 1'b0;
  end

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // Bits go out from first down to last, five cycles per half period.
  task automatic send_bits(input logic [15:0] word, input int first,
                           input int last);
    for (int i = first; i >= last; i--) begin
      @(posedge clk_sys_in);
      chip_select_n_out <= 1'b0;
      serial_clk_out <= 1'b0;
      serial_data_out <= word[i];
      wait_cycles(5);
      serial_clk_out <= 1'b1;
      wait_cycles(3);
      // Hold time is over, so the line must not keep showing the bit.
      serial_data_out <= ~word[i];
      wait_cycles(1);
    end
    @(posedge clk_sys_in);
    chip_select_n_out <= 1'b1;
  endtask

  // Chip select alone clocks the word while the link clock rests low.
  task automatic send_bits_cs(input logic [15:0] word);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys_in);
      serial_clk_out <= 1'b0;
      chip_select_n_out <= 1'b0;
      serial_data_out <= word[i];
      wait_cycles(5);
      chip_select_n_out <= 1'b1;
      wait_cycles(4);
    end
    @(posedge clk_sys_in);
    serial_clk_out <= 1'b1;
  endtask

  // The strobe stays low long enough for the synchroniser to see it.
  task automatic pulse_load();
    @(posedge clk_sys_in);
    channel_load_strobe_n_out <= 1'b0;
    wait_cycles(6);
    channel_load_strobe_n_out <= 1'b1;
    wait_cycles(6);
  endtask

  // Select settles before the reset pin moves.
  task automatic set_reset(input logic sel, input logic level);
    @(posedge clk_sys_in);
    reset_code_select_out <= sel;
    wait_cycles(3);
    device_reset_n_out <= level;
    wait_cycles(6);
  endtask
endmodule
`default_nettype wire

// ### bench/quad_load_control_tb.sv
// Self-checking testbench for the quad converter serial load control.
`timescale 1ns/1ns
`default_nettype none
module quad_load_control_tb;
  import quad_load_pkg::*;
  logic clk_sys_in;
  logic sys_rst_in;
  logic sdata, sclk, cs_n, load_n, rst_n, sel;
  logic ready;
  logic [CODE_BITS-1:0] code_a, code_b, code_c, code_d;
  logic [CODE_BITS-1:0] exp_code [4];
  int error_cnt = 0;
  int n_tests = 0;
  int cycle_cnt = 0;

  host_model host (.clk_sys_in(clk_sys_in), .serial_data_out(sdata),
    .serial_clk_out(sclk), .chip_select_n_out(cs_n),
    .channel_load_strobe_n_out(load_n), .device_reset_n_out(rst_n),
    .reset_code_select_out(sel));

  quad_load_control DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .serial_data_in(sdata), .serial_clk_in(sclk), .chip_select_n_in(cs_n),
    .channel_load_strobe_n_in(load_n), .device_reset_n_in(rst_n),
    .reset_code_select_in(sel), .bit_buffer_ready_out(ready),
    .channel_a_code_out(code_a), .channel_b_code_out(code_b),
    .channel_c_code_out(code_c), .channel_d_code_out(code_d));

  // A 125 MHz system clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] expected);
    n_tests++;
    if (seen !== expected) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen,
               expected);
    end
  endtask

  task automatic check_all();
    check(code_a, exp_code[0]);
    check(code_b, exp_code[1]);
    check(code_c, exp_code[2]);
    check(code_d, exp_code[3]);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Catches a hang; the run needs about 1300 cycles only.
  always @(posedge clk_sys_in) begin
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic t_reset_values();
    exp_code = '{12'h000, 12'h000, 12'h000, 12'h000};
    check_all();
    check({11'h000, ready}, 12'h001);
  endtask

  // Spare bits set high must not reach the codes.
  task automatic t_load_each();
    logic [11:0] codes [4];
    codes = '{12'h123, 12'hfff, 12'h001, 12'ha5c};
    for (int ch = 0; ch < 4; ch++) begin
      host.send_bits({ch[1:0], 2'b11, codes[ch]}, 15, 0);
      host.pulse_load();
      exp_code[ch] = codes[ch];
      check_all();
    end
  endtask

  task automatic t_latched();
    host.send_bits({2'b00, 2'b00, 12'h777}, 15, 0);
    host.wait_cycles(6);
    check_all();
  endtask

  task automatic t_dev_reset();
    host.set_reset(1'b1, 1'b0);
    exp_code = '{12'h800, 12'h800, 12'h800, 12'h800};
    check_all();
    host.pulse_load();
    check_all();
    host.set_reset(1'b1, 1'b1);
    check_all();
    host.set_reset(1'b0, 1'b0);
    exp_code = '{12'h000, 12'h000, 12'h000, 12'h000};
    check_all();
    host.set_reset(1'b0, 1'b1);
    check_all();
  endtask

  // Eight bits queue while reset stalls the drain, then the rest follow.
  task automatic t_buffer();
    logic [15:0] word;
    word = {2'b10, 2'b01, 12'h9b6};
    host.set_reset(1'b0, 1'b0);
    host.send_bits(word, 15, 8);
    check({11'h000, ready}, 12'h000);
    host.set_reset(1'b0, 1'b1);
    check({11'h000, ready}, 12'h001);
    host.send_bits(word, 7, 0);
    host.pulse_load();
    exp_code[2] = 12'h9b6;
    check_all();
  endtask

  // Chip select toggles as the shift clock with the link clock held low.
  task automatic t_cs_clocked();
    host.send_bits_cs({2'b11, 2'b10, 12'h3c5});
    host.pulse_load();
    exp_code[3] = 12'h3c5;
    check_all();
  endtask

  initial begin
    sys_rst_in = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    t_reset_values();
    t_load_each();
    t_latched();
    t_dev_reset();
    t_buffer();
    t_cs_clocked();
    test_done();
  end
endmodule
`default_nettype wire
